// ===== output_terminal_function_mux.sv
// Output terminal function mux: status flag select, polarity, registered drive.
// Assumes status flags are synchronous to clk; register access over Avalon-MM.
`timescale 1ns/10ps
module output_terminal_function_mux
#(
  parameter int NUM_TERM = outmux_pkg::N_TERM
)
(
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic [outmux_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic [31:0]                        avs_readdata,
  output logic                               avs_waitrequest,
  output logic [1:0]                         avs_response,
  input  wire logic                          running_flag,
  input  wire logic                          speed_reached_flag,
  input  wire logic                          above_freq_flag,
  input  wire logic                          overload_notice_flag,
  input  wire logic                          pid_deviation_flag,
  input  wire logic                          fault_flag,
  input  wire logic                          at_threshold_freq_flag,
  input  wire logic                          overtorque_flag,
  input  wire logic                          mains_loss_flag,
  input  wire logic                          undervolt_flag,
  input  wire logic                          torque_limit_flag,
  input  wire logic                          run_hours_over_flag,
  output logic [NUM_TERM-1:0]                term_out,
  output logic                               relay_out
);
  import outmux_pkg::*;

  // Readback and level packing assume exactly five terminals
  if (NUM_TERM != N_TERM)
  begin
    $error("NUM_TERM must equal five");
  end

  logic [POL_W-1:0]  pol_q [NUM_TERM];
  logic [POL_W-1:0]  relay_pol_q;
  logic [FUNC_W-1:0] fn_q [NUM_TERM];
  logic [FUNC_W-1:0] relay_fn_q;
  logic [N_FLAGS-1:0] flags;
  logic               ack_q;
  logic [NUM_TERM-1:0] term_d;
  logic               relay_d;

  // Upstream flags carry their own latching (fault stays until reset upstream)
  assign flags = {run_hours_over_flag, torque_limit_flag, undervolt_flag, mains_loss_flag,
                  overtorque_flag, at_threshold_freq_flag, fault_flag, pid_deviation_flag,
                  overload_notice_flag, above_freq_flag, speed_reached_flag, running_flag};

  // Unlisted codes read as inactive, so a stale setting drives a load only through a normally closed output
  function automatic logic select_flag(input logic [FUNC_W-1:0] fn, input logic [N_FLAGS-1:0] f);
    logic r;
    r = 1'b0;
    case (fn)
      FN_RUN:           r = f[0];
      FN_SPEED_REACHED: r = f[1];
      FN_ABOVE_FREQ:    r = f[2];
      FN_OVERLOAD:      r = f[3];
      FN_PID_DEV:       r = f[4];
      FN_FAULT:         r = f[5];
      FN_AT_THRESH:     r = f[6];
      FN_OVERTORQUE:    r = f[7];
      FN_MAINS_LOSS:    r = f[8];
      FN_UNDERVOLT:     r = f[9];
      FN_TORQUE_LIM:    r = f[10];
      FN_RUN_HOURS:     r = f[11];
      default:          r = 1'b0;
    endcase
    return r;
  endfunction

  // Only code 01 inverts; other values behave as normally open
  function automatic logic apply_pol(input logic s, input logic [POL_W-1:0] p);
    return (p == POL_NC) ? ~s : s;
  endfunction

  function automatic logic is_ofs(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base, input int idx);
    return a == ADDR_W'(int'(base) + 4 * idx);
  endfunction

  // One wait cycle per access keeps readdata registered
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_response    = 2'h0;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ack_q <= 1'b0;
    else
      ack_q <= (avs_read | avs_write) & ~ack_q;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_TERM; i++)
      begin
        pol_q[i] <= RST_TERM_POL;
        fn_q[i]  <= FUNC_W'(i);
      end
      relay_pol_q <= RST_RELAY_POL;
      relay_fn_q  <= RST_RELAY_FN;
    end
    else if (avs_write && ack_q && avs_byteenable[0])
    begin
      for (int i = 0; i < NUM_TERM; i++)
      begin
        if (is_ofs(avs_address, OFS_POL0, i))
          pol_q[i] <= avs_writedata[POL_W-1:0];
        else if (is_ofs(avs_address, OFS_FUNC0, i))
          fn_q[i] <= avs_writedata[FUNC_W-1:0];
      end
      if (avs_address == OFS_RLYPOL)
        relay_pol_q <= avs_writedata[POL_W-1:0];
      else if (avs_address == OFS_RLYFN)
        relay_fn_q <= avs_writedata[FUNC_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && !ack_q)
    begin
      avs_readdata <= 32'h0000_0000;
      for (int i = 0; i < NUM_TERM; i++)
      begin
        if (is_ofs(avs_address, OFS_POL0, i))
          avs_readdata <= {24'h00_0000, pol_q[i]};
        else if (is_ofs(avs_address, OFS_FUNC0, i))
          avs_readdata <= {27'h000_0000, fn_q[i]};
      end
      if (avs_address == OFS_RLYPOL)
        avs_readdata <= {24'h00_0000, relay_pol_q};
      else if (avs_address == OFS_RLYFN)
        avs_readdata <= {27'h000_0000, relay_fn_q};
      else if (avs_address == OFS_STAT)
        avs_readdata <= {20'h0_0000, flags};
      else if (avs_address == OFS_OUTS)
        avs_readdata <= {26'h000_0000, relay_out, term_out};
    end
  end

  always_comb
  begin
    for (int i = 0; i < NUM_TERM; i++)
      term_d[i] = apply_pol(select_flag(fn_q[i], flags), pol_q[i]);
    relay_d = apply_pol(select_flag(relay_fn_q, flags), relay_pol_q);
  end

  // Reset drive mirrors reset polarity with all flags low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      term_out  <= '0;
      relay_out <= 1'b1;
    end
    else
    begin
      term_out  <= term_d;
      relay_out <= relay_d;
    end
  end

  AST_TERM_FOLLOWS: assert property (@(posedge clk) disable iff (rst)
    1 |=> term_out[0] == apply_pol(select_flag($past(fn_q[0]), $past(flags)), $past(pol_q[0])))
    else $error("terminal 0 does not follow selected flag");
  AST_NO_PASSES: assert property (@(posedge clk) disable iff (rst)
    (pol_q[1] == POL_NO && fn_q[1] == FN_RUN) |=> term_out[1] == $past(running_flag))
    else $error("normally open terminal did not pass status");
  AST_NC_INVERTS: assert property (@(posedge clk) disable iff (rst)
    (pol_q[2] == POL_NC && fn_q[2] == FN_FAULT) |=> term_out[2] == !$past(fault_flag))
    else $error("normally closed terminal did not invert");
  AST_RELAY_RST: assert property (@(posedge clk)
    $fell(rst) |-> relay_pol_q == POL_NC)
    else $error("relay polarity reset value wrong");
  AST_TERM_RST: assert property (@(posedge clk)
    $fell(rst) |-> pol_q[4] == POL_NO && pol_q[0] == POL_NO)
    else $error("terminal polarity reset value wrong");
  AST_UNDERVOLT_T3: assert property (@(posedge clk) disable iff (rst)
    (fn_q[3] == FN_UNDERVOLT && pol_q[3] == POL_NO && undervolt_flag) |=> term_out[3])
    else $error("undervolt not shown");
  AST_RELAY_RUN_HOURS: assert property (@(posedge clk) disable iff (rst)
    (relay_fn_q == FN_RUN_HOURS && relay_pol_q == POL_NO) ##1 relay_fn_q == FN_RUN_HOURS
      |-> relay_out == $past(run_hours_over_flag))
    else $error("run hours relay mismatch");
  AST_WR_FN: assert property (@(posedge clk) disable iff (rst)
    (avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == OFS_FUNC0)
      |=> fn_q[0] == $past(avs_writedata[FUNC_W-1:0]))
    else $error("function select write lost");
  AST_WAIT_ONE: assert property (@(posedge clk) disable iff (rst)
    (avs_read && avs_waitrequest) |=> !avs_waitrequest)
    else $error("waitrequest longer than one cycle");

  // Per-code checks on terminal 0, the one every code is walked through
  AST_CODE_RUN: assert property (@(posedge clk) disable iff (rst)
    (fn_q[0] == FN_RUN && pol_q[0] == POL_NO)
      |=> term_out[0] == $past(running_flag))
    else $error("code 00 not shown on terminal 0");

  AST_CODE_SPEED: assert property (@(posedge clk) disable iff (rst)
    (fn_q[0] == FN_SPEED_REACHED && pol_q[0] == POL_NO)
      |=> term_out[0] == $past(speed_reached_flag))
    else $error("code 01 not shown on terminal 0");

  AST_CODE_ABOVE: assert property (@(posedge clk) disable iff (rst)
    (fn_q[0] == FN_ABOVE_FREQ && pol_q[0] == POL_NO)
      |=> term_out[0] == $past(above_freq_flag))
    else $error("code 02 not shown on terminal 0");

  AST_CODE_OVERLOAD: assert property (@(posedge clk) disable iff (rst)
    (fn_q[0] == FN_OVERLOAD && pol_q[0] == POL_NO)
      |=> term_out[0] == $past(overload_notice_flag))
    else $error("code 03 not shown on terminal 0");

  AST_CODE_PID: assert property (@(posedge clk) disable iff (rst)
    (fn_q[0] == FN_PID_DEV && pol_q[0] == POL_NO)
      |=> term_out[0] == $past(pid_deviation_flag))
    else $error("code 04 not shown on terminal 0");

  AST_CODE_FAULT: assert property (@(posedge clk) disable iff (rst)
    (fn_q[0] == FN_FAULT && pol_q[0] == POL_NO)
      |=> term_out[0] == $past(fault_flag))
    else $error("code 05 not shown on terminal 0");

  AST_CODE_AT_THRESH: assert property (@(posedge clk) disable iff (rst)
    (fn_q[0] == FN_AT_THRESH && pol_q[0] == POL_NO)
      |=> term_out[0] == $past(at_threshold_freq_flag))
    else $error("code 06 not shown on terminal 0");

  AST_CODE_OVERTORQUE: assert property (@(posedge clk) disable iff (rst)
    (fn_q[0] == FN_OVERTORQUE && pol_q[0] == POL_NO)
      |=> term_out[0] == $past(overtorque_flag))
    else $error("code 07 not shown on terminal 0");

  AST_CODE_MAINS: assert property (@(posedge clk) disable iff (rst)
    (fn_q[0] == FN_MAINS_LOSS && pol_q[0] == POL_NO)
      |=> term_out[0] == $past(mains_loss_flag))
    else $error("code 08 not shown on terminal 0");

  AST_CODE_UNDERVOLT: assert property (@(posedge clk) disable iff (rst)
    (fn_q[0] == FN_UNDERVOLT && pol_q[0] == POL_NO)
      |=> term_out[0] == $past(undervolt_flag))
    else $error("code 09 not shown on terminal 0");

  AST_CODE_TORQUE: assert property (@(posedge clk) disable iff (rst)
    (fn_q[0] == FN_TORQUE_LIM && pol_q[0] == POL_NO)
      |=> term_out[0] == $past(torque_limit_flag))
    else $error("code 10 not shown on terminal 0");

  AST_CODE_RUN_HOURS: assert property (@(posedge clk) disable iff (rst)
    (fn_q[0] == FN_RUN_HOURS && pol_q[0] == POL_NO)
      |=> term_out[0] == $past(run_hours_over_flag))
    else $error("code 11 not shown on terminal 0");

  // Relay sense in both polarities with the default fault code
  AST_RELAY_NC_FAULT: assert property (@(posedge clk) disable iff (rst)
    (relay_fn_q == FN_FAULT && relay_pol_q == POL_NC)
      |=> relay_out == !$past(fault_flag))
    else $error("normally closed relay did not invert fault");

  AST_RELAY_NO_FAULT: assert property (@(posedge clk) disable iff (rst)
    (relay_fn_q == FN_FAULT && relay_pol_q == POL_NO)
      |=> relay_out == $past(fault_flag))
    else $error("normally open relay did not pass fault");

  AST_RST_OUTS: assert property (@(posedge clk)
    $fell(rst) |-> relay_out && term_out == '0)
    else $error("output levels wrong after reset");

  // Register bus: one wait cycle; write lands and read data stands at the accepting edge
  AST_WAIT_FIRST: assert property (@(posedge clk) disable iff (rst)
    ((avs_read || avs_write) && !$past(avs_read || avs_write))
      |-> avs_waitrequest)
    else $error("new request not held off one cycle");

  AST_WAIT_WR: assert property (@(posedge clk) disable iff (rst)
    (avs_write && avs_waitrequest) |=> !avs_waitrequest)
    else $error("write waitrequest longer than one cycle");

  AST_WR_POL2: assert property (@(posedge clk) disable iff (rst)
    (avs_write && !avs_waitrequest && avs_byteenable[0] && is_ofs(avs_address, OFS_POL0, 2))
      |=> pol_q[2] == $past(avs_writedata[POL_W-1:0]))
    else $error("terminal polarity write lost");

  AST_WR_RELAY_POL: assert property (@(posedge clk) disable iff (rst)
    (avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == OFS_RLYPOL)
      |=> relay_pol_q == $past(avs_writedata[POL_W-1:0]))
    else $error("relay polarity write lost");

  AST_WR_REFUSED: assert property (@(posedge clk) disable iff (rst)
    (avs_write && !avs_byteenable[0]) |=> $stable(pol_q[1]) && $stable(fn_q[1]))
    else $error("write without lane 0 changed a setting");

  AST_RD_POL0: assert property (@(posedge clk) disable iff (rst)
    (avs_read && !avs_waitrequest && avs_address == OFS_POL0)
      |-> avs_readdata == {24'h00_0000, $past(pol_q[0])})
    else $error("terminal polarity readback wrong");

  AST_RD_RELAY_POL: assert property (@(posedge clk) disable iff (rst)
    (avs_read && !avs_waitrequest && avs_address == OFS_RLYPOL)
      |-> avs_readdata == {24'h00_0000, $past(relay_pol_q)})
    else $error("relay polarity readback wrong");

  AST_RD_RELAY_FN: assert property (@(posedge clk) disable iff (rst)
    (avs_read && !avs_waitrequest && avs_address == OFS_RLYFN)
      |-> avs_readdata == {27'h000_0000, $past(relay_fn_q)})
    else $error("relay function readback wrong");

  AST_RD_STATUS: assert property (@(posedge clk) disable iff (rst)
    (avs_read && !avs_waitrequest && avs_address == OFS_STAT)
      |-> avs_readdata == {20'h0_0000, $past(flags)})
    else $error("status readback wrong");

  AST_RD_OUTS: assert property (@(posedge clk) disable iff (rst)
    (avs_read && !avs_waitrequest && avs_address == OFS_OUTS)
      |-> avs_readdata == {26'h000_0000, $past(relay_out), $past(term_out)})
    else $error("output level readback wrong");

  COV_NC_TERM: cover property (@(posedge clk) disable iff (rst) pol_q[0] == POL_NC ##1 term_out[0]);
  COV_FAULT_RELAY: cover property (@(posedge clk) disable iff (rst) fault_flag ##1 !relay_out);
  COV_FN_WRITE: cover property (@(posedge clk) disable iff (rst) avs_write && !avs_waitrequest);
  COV_RELAY_RUN_HOURS: cover property (@(posedge clk) disable iff (rst) relay_fn_q == FN_RUN_HOURS ##1 relay_out);
  COV_REFUSED_WRITE: cover property (@(posedge clk) disable iff (rst) avs_write && !avs_byteenable[0]);
endmodule

// ===== outmux_pkg.sv
// Package for the output terminal function mux.
// Assumes a single 100 MHz clock domain and Avalon-MM register access.
package outmux_pkg;
  localparam int unsigned CLK_MHZ     = 100;
  localparam int          N_TERM      = 5;
  localparam int          FUNC_W      = 5;
  localparam int          POL_W       = 8;
  localparam int          ADDR_W      = 6;
  // Byte addresses (word aligned)
  localparam logic [ADDR_W-1:0] OFS_POL0   = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_RLYPOL = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_FUNC0  = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_RLYFN  = 6'h2C;
  localparam logic [ADDR_W-1:0] OFS_STAT   = 6'h30;
  localparam logic [ADDR_W-1:0] OFS_OUTS   = 6'h34;
  // Polarity codes
  localparam logic [POL_W-1:0] POL_NO = 8'h00;
  localparam logic [POL_W-1:0] POL_NC = 8'h01;
  // Reset values
  localparam logic [POL_W-1:0]  RST_TERM_POL  = POL_NO;
  localparam logic [POL_W-1:0]  RST_RELAY_POL = POL_NC;
  localparam logic [FUNC_W-1:0] RST_RELAY_FN  = 5'h05;
  // Function codes
  typedef enum logic [FUNC_W-1:0] {
    FN_RUN       = 5'h00,
    FN_SPEED_REACHED = 5'h01,
    FN_ABOVE_FREQ = 5'h02,
    FN_OVERLOAD  = 5'h03,
    FN_PID_DEV   = 5'h04,
    FN_FAULT     = 5'h05,
    FN_AT_THRESH = 5'h06,
    FN_OVERTORQUE = 5'h07,
    FN_MAINS_LOSS = 5'h08,
    FN_UNDERVOLT = 5'h09,
    FN_TORQUE_LIM = 5'h0A,
    FN_RUN_HOURS = 5'h0B
  } func_e;
  localparam int N_FLAGS = 12;
endpackage

// ===== outmux_load.sv
// Load model: relays and lamps hanging on the open-collector terminals.
// Assumes one load per terminal plus the alarm relay coil.
`timescale 1ns/10ps
module outmux_load
(
  input  wire logic [outmux_pkg::N_TERM-1:0] term_out,
  input  wire logic                          relay_out,
  output logic [outmux_pkg::N_TERM:0]        load_on
);
  import outmux_pkg::*;
  // Sinking transistor energizes its load while on; no delay modelled
  assign load_on = {relay_out, term_out};
endmodule

// ===== tb.sv
// Testbench for the output terminal function mux.
// Assumes Avalon-MM access with two-cycle answers and registered outputs.
`timescale 1ns/10ps
module tb;
  import outmux_pkg::*;
  logic              clk = 0, rst = 1, rd = 0, wr = 0, wait_r, rout;
  logic [ADDR_W-1:0] adr = '0;
  logic [31:0]       wd = '0, rdat, q;
  logic [3:0]        be = 4'hF;
  logic [1:0]        resp;
  logic [11:0]       fl = '0;
  logic [N_TERM-1:0] tout;
  logic [N_TERM:0]   load_on;
  int                num_errors = 0, n_checks = 0;
  always #5 clk = ~clk;
  output_terminal_function_mux output_terminal_function_mux_i (.clk(clk), .rst(rst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wait_r), .avs_response(resp), .running_flag(fl[0]), .speed_reached_flag(fl[1]),
    .above_freq_flag(fl[2]), .overload_notice_flag(fl[3]), .pid_deviation_flag(fl[4]), .fault_flag(fl[5]),
    .at_threshold_freq_flag(fl[6]), .overtorque_flag(fl[7]), .mains_loss_flag(fl[8]),
    .undervolt_flag(fl[9]), .torque_limit_flag(fl[10]), .run_hours_over_flag(fl[11]),
    .term_out(tout), .relay_out(rout));
  outmux_load outmux_load_i (.term_out(tout), .relay_out(rout), .load_on(load_on));
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // Request held until the edge that samples waitrequest low; one idle edge between calls
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wait_r !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    check("waitrequest", n < 20, 1);
    check("response", resp, 0);
    r = rdat;
    wr <= 0;
    rd <= 0;
  endtask
  // New flags at an edge land on the outputs one edge later
  task automatic apply(input logic [11:0] v);
    @(posedge clk);
    fl <= v;
    @(posedge clk);
    @(negedge clk);
  endtask
  task automatic test_reset;
    for (int i = 0; i < N_TERM; i++)
    begin
      bus(0, OFS_POL0 + 6'(4 * i), 0, q);
      check("term_pol", q, 0);
    end
    bus(0, OFS_RLYPOL, 0, q);
    check("relay_pol", q, 1);
    check("relay_idle", rout, 1);
    $display("test_reset done");
  endtask
  task automatic test_codes;
    for (int c = 0; c < 12; c++)
    begin
      bus(1, OFS_FUNC0, c, q);
      apply(12'h1 << c);
      check("code_on", tout[0], 1);
      apply(~(12'h1 << c));
      check("code_off", tout[0], 0);
    end
    $display("test_codes done");
  endtask
  task automatic test_polarity;
    bus(1, OFS_FUNC0 + 6'h8, 5, q);
    bus(1, OFS_POL0 + 6'h8, 1, q);
    apply(0);
    check("nc_idle", load_on[2], 1);
    apply(12'h020);
    check("nc_active", tout[2], 0);
    check("relay_nc_fault", rout, 0);
    bus(1, OFS_RLYPOL, 0, q);
    apply(12'h020);
    check("relay_no_on", rout, 1);
    apply(0);
    check("relay_no_off", rout, 0);
    $display("test_polarity done");
  endtask
  task automatic test_select;
    bus(1, OFS_FUNC0 + 6'hC, 6'h0B, q);
    bus(1, OFS_FUNC0 + 6'h10, 6'h07, q);
    bus(1, OFS_FUNC0 + 6'h4, 6'h00, q);
    bus(1, OFS_RLYFN, 6'h0B, q);
    apply(12'h801);
    check("independent", tout[4:3], 2'b01);
    check("term1_run", tout[1], 1);
    check("relay_run_hours", rout, 1);
    bus(0, OFS_STAT, 0, q);
    check("status", q, 32'h801);
    bus(0, OFS_OUTS, 0, q);
    check("levels", q, 32'h2F);
    bus(0, OFS_RLYFN, 0, q);
    check("relay_fn", q, 32'h0B);
    bus(1, OFS_FUNC0 + 6'hC, 6'h09, q);
    apply(12'h200);
    check("term3_undervolt", tout[3], 1);
    check("relay_run_hours_off", rout, 0);
    $display("test_select done");
  endtask
  task automatic test_timing;
    bus(1, OFS_FUNC0, 0, q);
    apply(0);
    @(posedge clk);
    fl <= 1;
    @(negedge clk);
    check("not_yet", tout[0], 0);
    @(negedge clk);
    check("registered", tout[0], 1);
    $display("test_timing done");
  endtask
  task automatic test_refused;
    @(posedge clk);
    be <= 4'h0;
    bus(1, OFS_POL0 + 6'h4, 1, q);
    be <= 4'hF;
    bus(0, OFS_POL0 + 6'h4, 0, q);
    check("no_lane0", q, 0);
    bus(0, 6'h3C, 0, q);
    check("unmapped", q, 0);
    $display("test_refused done");
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #200000;
    num_errors++;
    print_verdict;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 0;
    test_reset;
    test_codes;
    test_polarity;
    test_select;
    test_timing;
    test_refused;
    print_verdict;
  end
endmodule
